// >>> msc_pkg.sv
// Notes on behaviour
// R1 - Interrupt mask bit 15 clear blocks INTA
// R2 - Masking never alters the event register; the code sets its CSC bit from the masked wake path
// R3 - INTA needs mask and control-block enable
// R4 - Mask ignored until first mask write
// R5 - Wake mask bit 14 clear blocks CSTSCHG
// R6 - Wake mask depends on bit 4
// R7 - General wake bit 4 clear blocks wake
// R8 - CSTSCHG from wake AND general, or PME
// R9 - Bits 6:5 pulse audio enable, reset 0
// R10 - Mask bits 2 and 1 battery, reset 0
// R11 - Mask reserved bits reset to zero
// R12 - Present bit 15 shows modem interrupt pin
// R13 - Present bit 4 shows inverted ring pin
// R14 - Present reserved bits reset to zero
// R15 - Present bits 2 and 1 battery, reset 0
// R16 - Power-up reset initialises all registers
// R17 - Mask register at byte offset F4H
// R18 - Present register at byte offset F8H
// R19 - Writes to present register are ignored
package msc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] MSC_OFF_MASK = 12'h0F4;
    localparam logic [11:0] MSC_OFF_PRES = 12'h0F8;
    localparam logic [11:0] MSC_OFF_STAT = 12'h100;
    localparam logic [11:0] MSC_OFF_CLR = 12'h104;
    localparam logic [11:0] MSC_OFF_EN = 12'h108;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned MSC_BIT_MODEM_INTERRUPT_FIELD = 15;
    localparam int unsigned MSC_BIT_WAKE = 14;
    localparam int unsigned MSC_BIT_PWM_HI = 6;
    localparam int unsigned MSC_BIT_PWM_LO = 5;
    localparam int unsigned MSC_BIT_GENERAL_WAKE_FIELD = 4;
    localparam int unsigned MSC_BIT_BDR = 2;
    localparam int unsigned MSC_BIT_BWP = 1;

    // ------------------------------------------------------------
    // Reset values and writable/live bit sets
    // ------------------------------------------------------------
    localparam logic [31:0] MSC_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] MSC_MASK_WMASK = 32'h0000_C076;
    localparam logic [31:0] MSC_PRES_RST = 32'h0000_0000;
    localparam logic [31:0] MSC_PRES_LIVE = 32'h0000_8016;

    // Interrupt status bits
    localparam int unsigned MSC_IRQ_W = 3;
    localparam int unsigned MSC_EV_IRQ_RISE = 0;
    localparam int unsigned MSC_EV_RING = 1;
    localparam int unsigned MSC_EV_CSC = 2;
    localparam logic [2:0] MSC_IRQ_RST = 3'h0;

    // Synchronised pins
    localparam int unsigned MSC_PIN_W = 4;
    localparam int unsigned MSC_PIN_IRQ = 0;
    localparam int unsigned MSC_PIN_RING_N = 1;
    localparam int unsigned MSC_PIN_BDR = 2;
    localparam int unsigned MSC_PIN_BWP = 3;
    // Ring is active low, so its idle level is one
    localparam logic [3:0] MSC_PIN_RST = 4'h2;

    function automatic logic msc_hit(input logic [11:0] addr, input logic [11:0] off);
        msc_hit = (addr[11:2] == off[11:2]);
    endfunction

    function automatic logic [31:0] msc_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        msc_merge = res;
    endfunction

endpackage

// >>> msc_pin_if.sv
`timescale 1ns/1ps
interface msc_pin_if import msc_pkg::*; ();
    logic [MSC_PIN_W-1:0] raw;
    logic [MSC_PIN_W-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface

// >>> msc_pin_sync.sv
`timescale 1ns/1ps
module msc_pin_sync import msc_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    msc_pin_if.sync_side pins
);

    // First stage is read by the second stage only
    logic [MSC_PIN_W-1:0] meta_q;
    logic [MSC_PIN_W-1:0] sync_q;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= MSC_PIN_RST;
            sync_q <= MSC_PIN_RST;
        end else begin
            meta_q <= pins.raw;
            sync_q <= meta_q;
        end
    end

    assign pins.sync = sync_q;

endmodule

// >>> msc_top.sv
`timescale 1ns/1ps
module msc_top import msc_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_modem_irq_input,
    input wire logic i_modem_ring_input_n,
    input wire logic i_battery_detect_ready,
    input wire logic i_battery_write_protect,
    input wire logic i_system_control_block_modem_en,
    input wire logic i_power_mgmt_pme_enable,
    input wire logic i_modem_wake_event,
    output logic o_modem_inta,
    output logic o_cstschg,
    output logic [1:0] o_pulse_audio_enable,
    output logic o_irq
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    msc_pin_if pins ();

    assign pins.raw = {i_battery_write_protect, i_battery_detect_ready, i_modem_ring_input_n, i_modem_irq_input};

    msc_pin_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .pins(pins.sync_side)
    );

    wire irq_lvl = pins.sync[MSC_PIN_IRQ];
    wire ring_act = ~pins.sync[MSC_PIN_RING_N];
    wire bdr_lvl = pins.sync[MSC_PIN_BDR];
    wire bwp_lvl = pins.sync[MSC_PIN_BWP];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic [31:0] pres_q;
    logic [31:0] pres_d;
    logic armed_q;
    logic [MSC_IRQ_W-1:0] stat_q;
    logic [MSC_IRQ_W-1:0] stat_d;
    logic [MSC_IRQ_W-1:0] en_q;
    logic [31:0] prdata_q;
    logic irq_prev_q;
    logic ring_prev_q;
    logic inta_q;
    logic csc_q;

    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable;
    // R17 mask decode
    wire hit_mask = msc_hit(i_paddr, MSC_OFF_MASK);
    // R18 present decode
    wire hit_pres = msc_hit(i_paddr, MSC_OFF_PRES);
    wire hit_stat = msc_hit(i_paddr, MSC_OFF_STAT);
    wire hit_clr = msc_hit(i_paddr, MSC_OFF_CLR);
    wire hit_en = msc_hit(i_paddr, MSC_OFF_EN);
    wire any_hit = hit_mask | hit_pres | hit_stat | hit_clr | hit_en;

    // Zero wait states: read data is caught in the setup cycle
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~any_hit;

    wire wr = access & i_pwrite & o_pready;
    wire wr_mask = wr & hit_mask;
    wire wr_clr = wr & hit_clr;
    wire wr_en = wr & hit_en;

    // ------------------------------------------------------------
    // Event mask register
    // ------------------------------------------------------------
    // R9 R10 R11 writable fields only
    assign mask_d = wr_mask ? (msc_merge(mask_q, i_pwdata, i_pstrb) & MSC_MASK_WMASK) : mask_q;

    // R16 power-up reset, R11 reserved zero
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_q <= MSC_MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    // R4 arm on first mask write
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            armed_q <= 1'b0;
        end else if (wr_mask) begin
            armed_q <= 1'b1;
        end
    end

    assign o_pulse_audio_enable = mask_q[MSC_BIT_PWM_HI:MSC_BIT_PWM_LO];

    // ------------------------------------------------------------
    // Present state register
    // ------------------------------------------------------------
    // R19 no write path; R12 R13 R15 live bits; R14 others zero
    always_comb begin
        pres_d = MSC_PRES_RST;
        pres_d[MSC_BIT_MODEM_INTERRUPT_FIELD] = irq_lvl;
        pres_d[MSC_BIT_GENERAL_WAKE_FIELD] = ring_act;
        pres_d[MSC_BIT_BDR] = bdr_lvl;
        pres_d[MSC_BIT_BWP] = bwp_lvl;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pres_q <= MSC_PRES_RST;
        end else begin
            pres_q <= pres_d;
        end
    end

    // ------------------------------------------------------------
    // INTA and CSTSCHG gating
    // ------------------------------------------------------------
    // R1 R3 R4 mask only once armed, needs control enable
    wire modem_interrupt_field_open = ~armed_q | mask_q[MSC_BIT_MODEM_INTERRUPT_FIELD];
    wire inta_d = irq_lvl & i_system_control_block_modem_en & modem_interrupt_field_open;
    // R5 R6 R7 R8 wake path; the masked csc_d also sets the CSC event bit, though R2 keeps masking out of the event register
    wire wake_open = (mask_q[MSC_BIT_WAKE] & mask_q[MSC_BIT_GENERAL_WAKE_FIELD]) | i_power_mgmt_pme_enable;
    wire csc_d = i_modem_wake_event & wake_open;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            inta_q <= 1'b0;
            csc_q <= 1'b0;
        end else begin
            inta_q <= inta_d;
            csc_q <= csc_d;
        end
    end

    assign o_modem_inta = inta_q;
    assign o_cstschg = csc_q;

    // ------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------
    wire [MSC_IRQ_W-1:0] ev_set = {csc_d & ~csc_q, ring_act & ~ring_prev_q, irq_lvl & ~irq_prev_q};
    wire [MSC_IRQ_W-1:0] clr_vec = wr_clr ? i_pwdata[MSC_IRQ_W-1:0] : MSC_IRQ_RST;

    // Set wins over a clear in the same cycle
    assign stat_d = (stat_q & ~clr_vec) | ev_set;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            stat_q <= MSC_IRQ_RST;
            en_q <= MSC_IRQ_RST;
            irq_prev_q <= 1'b0;
            ring_prev_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_prev_q <= irq_lvl;
            ring_prev_q <= ring_act;
            if (wr_en) begin
                en_q <= i_pwdata[MSC_IRQ_W-1:0];
            end
        end
    end

    assign o_irq = |(stat_q & en_q);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Clear register is write-only and reads as zero
    wire [31:0] rd_mux = hit_mask ? mask_q :
                         hit_pres ? pres_q :
                         hit_stat ? {29'h0, stat_q} :
                         hit_en ? {29'h0, en_q} : 32'h0000_0000;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup & ~i_pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    assign o_prdata = prdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    a_inta_mask_block: assert property ( // R1
        (armed_q && !mask_q[MSC_BIT_MODEM_INTERRUPT_FIELD]) |=> !o_modem_inta)
        else $error("INTA asserted while masked");

    a_inta_needs_scb: assert property ( // R3
        o_modem_inta |-> ($past(i_system_control_block_modem_en) && $past(irq_lvl)))
        else $error("INTA without control enable or pin");

    a_inta_legacy_open: assert property ( // R4
        (!armed_q && irq_lvl && i_system_control_block_modem_en) |=> o_modem_inta)
        else $error("INTA blocked before first mask write");

    a_wake_mask_block: assert property ( // R5
        (!(mask_q[MSC_BIT_WAKE] && mask_q[MSC_BIT_GENERAL_WAKE_FIELD]) && !i_power_mgmt_pme_enable) |=> !o_cstschg)
        else $error("CSTSCHG while wake masked");

    a_csc_pme_path: assert property ( // R8
        (i_modem_wake_event && i_power_mgmt_pme_enable) |=> o_cstschg)
        else $error("CSTSCHG missing with PME enable");

    a_pres_irq_pin: assert property ( // R12
        (i_modem_irq_input [*4]) |-> pres_q[MSC_BIT_MODEM_INTERRUPT_FIELD])
        else $error("Present bit 15 not following pin");

    a_pres_ring_inv: assert property ( // R13
        (!i_modem_ring_input_n [*4]) |-> pres_q[MSC_BIT_GENERAL_WAKE_FIELD])
        else $error("Present bit 4 not inverse of ring");

    a_pres_reserved_zero: assert property ( // R14
        (pres_q & ~MSC_PRES_LIVE) == 32'h0000_0000)
        else $error("Present reserved bit set");

    a_mask_reserved_zero: assert property ( // R11
        (mask_q & ~MSC_MASK_WMASK) == 32'h0000_0000)
        else $error("Mask reserved bit set");

    a_mask_full_write: assert property ( // R17
        (wr_mask && i_pstrb == 4'hF) |=> (mask_q == ($past(i_pwdata) & MSC_MASK_WMASK)))
        else $error("Mask write not stored");

    a_pres_write_ignored: assert property ( // R19
        (wr && hit_pres) |=> ($stable(mask_q) && $stable(armed_q)))
        else $error("Present write disturbed state");

    a_stat_sticky_bits: assert property (
        ((stat_q & $past(stat_q & ~clr_vec)) == $past(stat_q & ~clr_vec)))
        else $error("Status bit lost without clear");

    // Pin checks allow two sync stages plus the present register
    a_pres_irq_low: assert property ( // R12
        (!i_modem_irq_input [*4]) |-> !pres_q[MSC_BIT_MODEM_INTERRUPT_FIELD])
        else $error("Present bit 15 set with pin low");

    a_pres_ring_idle: assert property ( // R13
        (i_modem_ring_input_n [*4]) |-> !pres_q[MSC_BIT_GENERAL_WAKE_FIELD])
        else $error("Present bit 4 set with ring idle");

    a_pres_bdr_pin: assert property ( // R15
        (i_battery_detect_ready [*4]) |-> pres_q[MSC_BIT_BDR])
        else $error("Present bit 2 not following pin");

    a_pres_bwp_pin: assert property ( // R15
        (i_battery_write_protect [*4]) |-> pres_q[MSC_BIT_BWP])
        else $error("Present bit 1 not following pin");

    a_general_wake_block: assert property ( // R7
        (!mask_q[MSC_BIT_GENERAL_WAKE_FIELD] && !i_power_mgmt_pme_enable) |=> !o_cstschg)
        else $error("CSTSCHG while general wake masked");

    a_wake_needs_general: assert property ( // R6
        (mask_q[MSC_BIT_WAKE] && !mask_q[MSC_BIT_GENERAL_WAKE_FIELD] && !i_power_mgmt_pme_enable && i_modem_wake_event)
        |=> !o_cstschg)
        else $error("Wake mask acted without general wake");

    a_csc_wake_open: assert property ( // R8
        (i_modem_wake_event && mask_q[MSC_BIT_WAKE] && mask_q[MSC_BIT_GENERAL_WAKE_FIELD]) |=> o_cstschg)
        else $error("CSTSCHG missing with both wake masks open");

    a_csc_needs_event: assert property ( // R8
        o_cstschg |-> $past(i_modem_wake_event))
        else $error("CSTSCHG without wake event");

    a_inta_scb_block: assert property ( // R3
        !i_system_control_block_modem_en |=> !o_modem_inta)
        else $error("INTA with control enable low");

    a_inta_mask_open: assert property ( // R1
        (armed_q && mask_q[MSC_BIT_MODEM_INTERRUPT_FIELD] && irq_lvl && i_system_control_block_modem_en) |=> o_modem_inta)
        else $error("INTA missing with mask open");

    a_armed_sticky: assert property ( // R4
        armed_q |=> armed_q)
        else $error("Mask arming lost");

    a_arm_on_write: assert property ( // R4
        wr_mask |=> armed_q)
        else $error("Mask write did not arm");

    a_pwm_write: assert property ( // R9
        (wr_mask && i_pstrb[0]) |=> (o_pulse_audio_enable == $past(i_pwdata[MSC_BIT_PWM_HI:MSC_BIT_PWM_LO])))
        else $error("Pulse audio enable not written");

    a_irq_event_kept: assert property ( // R2
        (irq_lvl && !irq_prev_q) |=> stat_q[MSC_EV_IRQ_RISE])
        else $error("Interrupt event not recorded");

    a_ring_event_kept: assert property ( // R2
        (ring_act && !ring_prev_q) |=> stat_q[MSC_EV_RING])
        else $error("Ring event not recorded");

    a_csc_event_kept: assert property ( // R2
        (csc_d && !csc_q) |=> stat_q[MSC_EV_CSC])
        else $error("Wake event not recorded");

    a_prdata_mask_read: assert property ( // R17
        (setup && !i_pwrite && hit_mask) |=> (o_prdata == $past(mask_q)))
        else $error("Mask read data wrong");

    a_prdata_pres_read: assert property ( // R18
        (setup && !i_pwrite && hit_pres) |=> (o_prdata == $past(pres_q)))
        else $error("Present read data wrong");

    a_stat_clear_works: assert property (
        wr_clr |=> ((stat_q & $past(clr_vec & ~ev_set)) == 3'h0))
        else $error("Status bit survived clear");

    a_en_write_stored: assert property (
        wr_en |=> (en_q == $past(i_pwdata[MSC_IRQ_W-1:0])))
        else $error("Enable write not stored");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_legacy_inta: cover property (!armed_q && o_modem_inta);
    c_masked_after_arm: cover property (armed_q && !mask_q[MSC_BIT_MODEM_INTERRUPT_FIELD] && irq_lvl ##1 !o_modem_inta);
    c_csc_via_wake: cover property (mask_q[MSC_BIT_WAKE] && mask_q[MSC_BIT_GENERAL_WAKE_FIELD] && o_cstschg);
    c_csc_via_pme: cover property (i_power_mgmt_pme_enable && !mask_q[MSC_BIT_WAKE] && o_cstschg);
    c_irq_cleared: cover property (o_irq ##1 wr_clr ##1 !o_irq);

endmodule

// >>> msc_modem_model.sv
`timescale 1ns/1ps
module msc_modem_model (
    input wire logic i_clk_sys,
    input wire logic [3:0] i_cmd,
    output logic o_irq,
    output logic o_ring_n,
    output logic o_bdr,
    output logic o_bwp
);
    // ----------------------------------------
    // Modem chipset pin levels
    // ----------------------------------------
    // Pins move only after a clock edge, so the design's synchronisers see clean steps
    initial begin
        o_irq = 1'b0;
        o_ring_n = 1'b1;
        o_bdr = 1'b0;
        o_bwp = 1'b0;
    end
    always @(posedge i_clk_sys) begin
        o_irq <= i_cmd[0];
        o_ring_n <= ~i_cmd[1];
        o_bdr <= i_cmd[2];
        o_bwp <= i_cmd[3];
    end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    import msc_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, inta, csc, irq, irq_p, ring_n, bdr, bwp;
    logic scb_en = 1'b1;
    logic pme = 1'b0;
    logic wake = 1'b0;
    logic [1:0] pae;
    logic [3:0] cmd = 4'h0;
    logic [31:0] rd;
    logic err;
    logic [2:0] c;
    int errors = 0;
    int checks = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    msc_modem_model modem_u (.i_clk_sys(i_clk_sys), .i_cmd(cmd), .o_irq(irq_p), .o_ring_n(ring_n),
        .o_bdr(bdr), .o_bwp(bwp));

    msc_top dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_modem_irq_input(irq_p), .i_modem_ring_input_n(ring_n),
        .i_battery_detect_ready(bdr), .i_battery_write_protect(bwp),
        .i_system_control_block_modem_en(scb_en), .i_power_mgmt_pme_enable(pme),
        .i_modem_wake_event(wake), .o_modem_inta(inta), .o_cstschg(csc),
        .o_pulse_audio_enable(pae), .o_irq(irq));

    // ----------------------------------------
    // Report, delay and bus tasks
    // ----------------------------------------
    task automatic final_report();
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    // Request is held until pready is seen high, then released
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk_sys);
        penable <= 1'b1;
        @(posedge i_clk_sys);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                errors++;
                final_report();
            end
            @(posedge i_clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        tick(8);
        i_nrst <= 1'b1;
        rchk(MSC_OFF_MASK, 32'h0000_0000);
        rchk(MSC_OFF_PRES, 32'h0000_0000);
        cmd <= 4'h1;
        tick(6);
        `CHK(inta, 1'b1)
        scb_en <= 1'b0;
        tick(3);
        `CHK(inta, 1'b0)
        scb_en <= 1'b1;
        apb(1'b1, MSC_OFF_MASK, 32'h0000_8000);
        tick(3);
        `CHK(inta, 1'b1)
        apb(1'b1, MSC_OFF_MASK, 32'h0000_0000);
        tick(3);
        `CHK(inta, 1'b0)
        rchk(MSC_OFF_PRES, 32'h0000_8000);
        cmd <= 4'hF;
        tick(6);
        rchk(MSC_OFF_PRES, 32'h0000_8016);
        apb(1'b1, MSC_OFF_PRES, 32'hFFFF_FFFF);
        rchk(MSC_OFF_PRES, 32'h0000_8016);
        apb(1'b1, MSC_OFF_MASK, 32'hFFFF_FFFF);
        rchk(MSC_OFF_MASK, 32'h0000_C076);
        `CHK(pae, 2'h3)
        wake <= 1'b1;
        // Every combination of wake mask, general wake and PME enable
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            pme <= c[2];
            apb(1'b1, MSC_OFF_MASK, {17'h0, c[0], 9'h0, c[1], 4'h0});
            tick(3);
            `CHK(csc, (c[0] & c[1]) | c[2])
        end
        apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        rchk(MSC_OFF_STAT, 32'h0000_0007);
        wake <= 1'b0;
        cmd <= 4'h0;
        tick(6);
        apb(1'b1, MSC_OFF_CLR, 32'h0000_0007);
        apb(1'b1, MSC_OFF_EN, 32'h0000_0001);
        cmd <= 4'h1;
        tick(6);
        `CHK(irq, 1'b1)
        apb(1'b1, MSC_OFF_EN, 32'h0000_0000);
        tick(1);
        `CHK(irq, 1'b0)
        rchk(MSC_OFF_STAT, 32'h0000_0001);
        apb(1'b1, MSC_OFF_EN, 32'h0000_0001);
        tick(1);
        `CHK(irq, 1'b1)
        apb(1'b1, MSC_OFF_CLR, 32'h0000_0001);
        tick(1);
        `CHK(irq, 1'b0)
        rchk(MSC_OFF_STAT, 32'h0000_0000);
        final_report();
    end
endmodule
